/* File: src/aux_load_sync.v */
// Purpose: Carries a written aux period into the aux tick domain.
// Assumes: tick is the aux rate enable; wr is a one-cycle pulse.
// Notes: A write while pending restarts the transfer with the newer value.
`timescale 1ns/100ps
`include "pit_consts.vh"
`default_nettype none
module aux_load_sync #(
    parameter SYNC_TICKS = `SYNC_TICKS
) (
    input wire clk,
    input wire rstn,
    input wire tick,
    input wire wr,
    input wire [31:0] wdata,
    output reg [31:0] aux_load_reg,
    output reg done_reg
);
    reg [31:0] hold_reg; // Value waiting to cross
    reg pend_reg; // Transfer in progress
    reg [3:0] stage_reg; // Aux ticks seen so far

    // ***************************************************************
    // Transfer sequencer
    // ***************************************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aux_load_reg <= `RST_WORD;
            hold_reg <= `RST_WORD;
            pend_reg <= 1'b0;
            stage_reg <= 4'h0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (wr) begin
                hold_reg <= wdata;
                pend_reg <= 1'b1;
                stage_reg <= 4'h0;
            end else if (pend_reg && tick) begin
                if (stage_reg == SYNC_TICKS[3:0] - 4'h1) begin
                    // Several aux ticks elapsed: value now owned by aux side
                    aux_load_reg <= hold_reg; // R15
                    pend_reg <= 1'b0;
                    done_reg <= 1'b1; // R15
                end else begin
                    stage_reg <= stage_reg + 4'h1;
                end
            end
        end
    end
endmodule // aux_load_sync
`default_nettype wire

/* File: src/interval_timer_bank.v */
// Purpose: Bank of periodic interval timers with an aux real-time timer, APB slave.
// Assumes: NUM_CH is 2..4; debug halt pin is asynchronous to CLK_SYS.
// Notes: Zero-wait APB with registered answer; unmapped access gives PSLVERR.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "pit_consts.vh"
`default_nettype none
module interval_timer_bank #(
    parameter NUM_CH = `NCH_DEF,
    parameter AUX_DIV = `AUX_DIV_DEF
) (
    input wire CLK_SYS,
    input wire RSTN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire DEBUG_HALT,
    output reg [NUM_CH-1:0] CHAN_TRIG,
    output reg AUX_TRIG,
    output reg [NUM_CH-1:0] CHAN_IRQ,
    output reg AUX_IRQ
);
    // ***************************************************************
    // Address decode helpers
    // ***************************************************************

    // True when an address falls on an implemented channel word
    function chan_hit;
        input [11:0] a;
        begin
            chan_hit = (a[11:8] == `CH_REGION) && (a[7:6] == 2'h0) &&
                (a[1:0] == 2'h0) && ({30'h0, a[5:4]} < NUM_CH);
        end
    endfunction

    // True when an address names a global or aux word
    function glob_hit;
        input [11:0] a;
        begin
            glob_hit = (a[1:0] == 2'h0) && (a <= `OFS_LIFE_LO);
        end
    endfunction

    // ***************************************************************
    // Storage
    // ***************************************************************
    reg [31:0] ld_reg [0:NUM_CH-1]; // Channel periods
    reg [NUM_CH-1:0] en_reg; // Channel run bits
    reg [NUM_CH-1:0] ie_reg; // channel_irq_enable bits
    reg [NUM_CH-1:0] chain_reg; // Chain-to-previous bits
    reg [NUM_CH-1:0] flag_reg; // channel_timeout_flag bits
    reg debug_run_select_reg; // Run timers while halted in debug
    reg aux_en_reg; // Aux run bit
    reg aux_irq_enable_reg; // Aux interrupt enable
    reg aux_timeout_flag_reg; // Aux expiry flag
    reg aux_load_synced_flag_reg; // Aux load transfer finished
    reg [31:0] aux_wval_reg; // Last written aux period, readback
    reg [31:0] lo_snap_reg; // Channel 0 captured with the upper word
    reg halt_s1_reg; // First synchroniser stage, read only by stage two
    reg halt_s2_reg; // Synchronised debug halt
    reg [15:0] div_reg; // Aux tick divider
    reg aux_tick_reg; // One-cycle aux rate enable
    reg [31:0] rd_next; // Read data being assembled

    wire [NUM_CH*32-1:0] cnt_all; // All channel counts, flattened
    wire [NUM_CH-1:0] expire; // Channel expiry strobes
    wire [NUM_CH-1:0] step; // Channel step enables
    wire [31:0] aux_count; // Aux counter value
    wire [31:0] aux_load; // Aux period on the aux side
    wire aux_expire; // Aux expiry strobe
    wire aux_done; // Aux load transfer done
    wire freeze; // All timers held for debug
    wire setup; // APB setup phase
    wire wr_en; // APB write takes effect
    wire [1:0] ch_sel; // Channel addressed
    wire [1:0] ch_word; // Word inside channel
    wire aux_load_wr; // Write to the aux period
    integer i;

    assign setup = PSEL & ~PENABLE;
    assign wr_en = PSEL & PENABLE & PWRITE & PREADY & ~PSLVERR;
    assign ch_sel = PADDR[5:4];
    assign ch_word = PADDR[3:2];
    assign aux_load_wr = wr_en && (PADDR == `OFS_AUX_LOAD);
    // Default freezes; select bit lets timers run through a debug halt
    assign freeze = halt_s2_reg & ~debug_run_select_reg; // R9

    // ***************************************************************
    // Debug halt synchroniser and aux tick divider
    // ***************************************************************
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            halt_s1_reg <= 1'b0;
            halt_s2_reg <= 1'b0;
            div_reg <= 16'h0000;
            aux_tick_reg <= 1'b0;
        end else begin
            halt_s1_reg <= DEBUG_HALT;
            halt_s2_reg <= halt_s1_reg;
            // Divider keeps running in debug so the load transfer still completes
            if (div_reg == AUX_DIV[15:0] - 16'h0001) begin
                div_reg <= 16'h0000;
                aux_tick_reg <= 1'b1;
            end else begin
                div_reg <= div_reg + 16'h0001;
                aux_tick_reg <= 1'b0;
            end
        end
    end

    // ***************************************************************
    // Channel counters
    // ***************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : chan
            if (g == 0) begin : first
                // Channel 0 has nothing to chain to
                assign step[g] = ~freeze; // R13
            end else begin : later
                // Chained channel steps once per expiry of the one before
                assign step[g] = ~freeze & (chain_reg[g] ? expire[g-1] : 1'b1); // R13 R7
            end
            period_down_counter u_cnt (
                .clk(CLK_SYS),
                .rstn(RSTN),
                .enable(en_reg[g]), // R10
                .step(step[g]),
                .load_val(ld_reg[g]),
                .count_reg(cnt_all[g*32 +: 32]),
                .expire(expire[g])
            );
        end
    endgenerate

    // ***************************************************************
    // Aux real-time timer
    // ***************************************************************
    aux_load_sync u_sync (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .tick(aux_tick_reg),
        .wr(aux_load_wr),
        .wdata(PWDATA),
        .aux_load_reg(aux_load),
        .done_reg(aux_done)
    );

    // Aux counter steps only at the aux rate
    period_down_counter u_aux (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .enable(aux_en_reg), // R2 R4
        .step(aux_tick_reg & ~freeze), // R9
        .load_val(aux_load),
        .count_reg(aux_count),
        .expire(aux_expire)
    );

    // ***************************************************************
    // Software registers and flags
    // ***************************************************************
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            for (i = 0; i < NUM_CH; i = i + 1) begin
                ld_reg[i] <= `RST_WORD;
            end
            en_reg <= {NUM_CH{1'b0}}; // R18
            ie_reg <= {NUM_CH{1'b0}}; // R18
            chain_reg <= {NUM_CH{1'b0}}; // R18
            flag_reg <= {NUM_CH{1'b0}}; // R18
            debug_run_select_reg <= 1'b0; // R18 R9
            aux_en_reg <= 1'b0;
            aux_irq_enable_reg <= 1'b0;
            aux_timeout_flag_reg <= 1'b0;
            aux_load_synced_flag_reg <= 1'b0;
            aux_wval_reg <= `RST_WORD;
        end else begin
            // Channel words
            for (i = 0; i < NUM_CH; i = i + 1) begin
                if (wr_en && chan_hit(PADDR) && (ch_sel == i[1:0])) begin
                    if (ch_word == `CH_LOAD) begin
                        // Running counter untouched; value used at next reload
                        ld_reg[i] <= PWDATA; // R14
                    end
                    if (ch_word == `CH_CTRL) begin
                        en_reg[i] <= PWDATA[`BIT_EN]; // R1
                        ie_reg[i] <= PWDATA[`BIT_IE]; // R11
                        // Channel 0 chain bit stays zero
                        chain_reg[i] <= PWDATA[`BIT_CHAIN] & (i != 0); // R13
                    end
                end
                // Set beats a write-one clear in the same cycle
                if (expire[i]) begin
                    flag_reg[i] <= 1'b1; // R16
                end else if (wr_en && chan_hit(PADDR) && (ch_sel == i[1:0]) &&
                    (ch_word == `CH_FLAG) && PWDATA[`BIT_FLAG]) begin
                    flag_reg[i] <= 1'b0; // R17
                end
            end
            // Global and aux words
            if (wr_en && (PADDR == `OFS_GCTRL)) begin
                debug_run_select_reg <= PWDATA[`BIT_DBG_RUN]; // R9
            end
            if (aux_load_wr) begin
                aux_wval_reg <= PWDATA;
            end
            if (wr_en && (PADDR == `OFS_AUX_CTRL)) begin
                aux_en_reg <= PWDATA[`BIT_EN]; // R2 R4
                aux_irq_enable_reg <= PWDATA[`BIT_IE]; // R11
            end
            if (aux_expire) begin
                aux_timeout_flag_reg <= 1'b1; // R3
            end else if (wr_en && (PADDR == `OFS_AUX_FLAG) && PWDATA[`BIT_FLAG]) begin
                aux_timeout_flag_reg <= 1'b0; // R17
            end
            if (aux_done) begin
                aux_load_synced_flag_reg <= 1'b1; // R12 R15
            end else if ((wr_en && (PADDR == `OFS_AUX_SYNC) && PWDATA[`BIT_FLAG]) ||
                aux_load_wr) begin
                // A new load also withdraws the old completion
                aux_load_synced_flag_reg <= 1'b0; // R12
            end
        end
    end

    // ***************************************************************
    // Read data mux
    // ***************************************************************
    always @* begin
        rd_next = `RST_WORD;
        if (chan_hit(PADDR)) begin
            case (ch_word)
                `CH_LOAD: rd_next = ld_reg[ch_sel];
                `CH_COUNT: rd_next = cnt_all[ch_sel*32 +: 32];
                `CH_CTRL: rd_next = {29'h0, chain_reg[ch_sel], ie_reg[ch_sel],
                    en_reg[ch_sel]};
                default: rd_next = {31'h0, flag_reg[ch_sel]};
            endcase
        end else begin
            case (PADDR)
                `OFS_GCTRL: rd_next = {31'h0, debug_run_select_reg};
                `OFS_AUX_LOAD: rd_next = aux_wval_reg;
                `OFS_AUX_COUNT: rd_next = aux_count;
                `OFS_AUX_CTRL: rd_next = {30'h0, aux_irq_enable_reg, aux_en_reg};
                `OFS_AUX_FLAG: rd_next = {31'h0, aux_timeout_flag_reg};
                `OFS_AUX_SYNC: rd_next = {31'h0, aux_load_synced_flag_reg}; // R12
                `OFS_LIFE_HI: rd_next = cnt_all[63:32]; // R6
                `OFS_LIFE_LO: rd_next = lo_snap_reg; // R6
                default: rd_next = `RST_WORD;
            endcase
        end
    end

    // ***************************************************************
    // APB answer and lifetime snapshot
    // ***************************************************************
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA <= `RST_WORD;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            lo_snap_reg <= `RST_WORD;
        end else begin
            // Answer lands in the first access cycle, one cycle after setup
            PREADY <= setup;
            PSLVERR <= setup & ~(chan_hit(PADDR) | glob_hit(PADDR));
            if (setup && !PWRITE) begin
                PRDATA <= rd_next;
            end
            // Reading the upper word freezes the lower, so both halves agree
            if (setup && !PWRITE && (PADDR == `OFS_LIFE_HI)) begin
                lo_snap_reg <= cnt_all[31:0]; // R5
            end
        end
    end

    // ***************************************************************
    // Triggers and interrupt requests
    // ***************************************************************
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            CHAN_TRIG <= {NUM_CH{1'b0}};
            AUX_TRIG <= 1'b0;
            CHAN_IRQ <= {NUM_CH{1'b0}};
            AUX_IRQ <= 1'b0;
        end else begin
            CHAN_TRIG <= expire; // R16
            AUX_TRIG <= aux_expire; // R3
            CHAN_IRQ <= flag_reg & ie_reg; // R17 R11
            AUX_IRQ <= aux_timeout_flag_reg & aux_irq_enable_reg; // R17
        end
    end
endmodule // interval_timer_bank
`default_nettype wire

/* File: src/period_down_counter.v */
// Purpose: One reloading 32-bit down counter.
// Assumes: step is a one-cycle enable on the system clock.
// Notes: Period is load+1 steps; expire is combinational for chaining.
`timescale 1ns/100ps
`include "pit_consts.vh"
`default_nettype none
module period_down_counter (
    input wire clk,
    input wire rstn,
    input wire enable,
    input wire step,
    input wire [31:0] load_val,
    output reg [31:0] count_reg,
    output wire expire
);
    reg en_d_reg; // Enable seen last cycle, for start detection

    // Expiry: a step taken while the count sits at zero
    assign expire = enable & en_d_reg & step & (count_reg == 32'h0000_0000); // R16 R3

    // ***************************************************************
    // Counter
    // ***************************************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= `RST_WORD; // R18
            en_d_reg <= 1'b0;
        end else begin
            en_d_reg <= enable;
            if (enable && !en_d_reg) begin
                // Fresh start always takes the full period, never the old count
                count_reg <= load_val; // R1 R4
            end else if (expire) begin
                // Load also read at a fresh start; otherwise a new period waits for expiry
                count_reg <= load_val; // R14 R2
            end else if (enable && step) begin
                count_reg <= count_reg - 32'h0000_0001;
            end
            // Disabled: count simply holds
        end
    end
endmodule // period_down_counter
`default_nettype wire

/* File: src/pit_consts.vh */
// Purpose: Constants shared by the periodic interval timer bank.
// Assumes: 32-bit APB data, byte addresses, one system clock.
// Notes: Offsets are byte addresses; channel n sits at 0x100 + n*0x10.
//
// Operation
// R1: Stopped channel holds; restart reloads period
// R2: Aux timer loads, counts, reloads continuously
// R3: Aux zero gives trigger pulse, sets flag
// R4: Aux stop halts; restart reloads full period
// R5: Channels 0,1 chained read as 64 bits
// R6: Upper word channel 1, lower channel 0
// R7: Lifetime period is product of both periods
// R8: Software enables chaining before using lifetime
// R9: Debug select runs or freezes; default freeze
// R10: Channels 0..3, count is a parameter
// R11: Separate flag and enable per timer
// R12: Readable aux load transferred status flag
// R13: Chained channel steps on previous expiry only
// R14: New period waits for next reload
// R15: Aux load crosses after aux ticks, flag set
// R16: Channel zero gives trigger pulse, sets flag
// R17: Request while flag and enable; write-one clears
// R18: Reset stops all, clears flags and enables
`ifndef PIT_CONSTS_VH
`define PIT_CONSTS_VH
// ***************************************************************
// Register offsets
// ***************************************************************
`define OFS_GCTRL 12'h000
`define OFS_AUX_LOAD 12'h004
`define OFS_AUX_COUNT 12'h008
`define OFS_AUX_CTRL 12'h00C
`define OFS_AUX_FLAG 12'h010
`define OFS_AUX_SYNC 12'h014
`define OFS_LIFE_HI 12'h018
`define OFS_LIFE_LO 12'h01C
`define CH_REGION 4'h1
`define CH_LOAD 2'h0
`define CH_COUNT 2'h1
`define CH_CTRL 2'h2
`define CH_FLAG 2'h3
// ***************************************************************
// Field positions
// ***************************************************************
`define BIT_DBG_RUN 0
`define BIT_EN 0
`define BIT_IE 1
`define BIT_CHAIN 2
`define BIT_FLAG 0
// ***************************************************************
// Reset values and timing
// ***************************************************************
`define RST_WORD 32'h0000_0000
`define NCH_DEF 4
`define AUX_DIV_DEF 4
`define SYNC_TICKS 3
`endif

/* File: tb/interval_timer_bank_chk.sv */
// Purpose: Port checker for the interval timer bank.
// Assumes: AUX_DIV of 4.
// Notes: Bind at the foot.
`timescale 1ns/100ps
`default_nettype none
module timer_bank_chk #(
    parameter NUM_CH = 4,
    parameter AUX_DIV = 4
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [NUM_CH-1:0] CHAN_TRIG,
    input wire logic AUX_TRIG,
    input wire logic [NUM_CH-1:0] CHAN_IRQ,
    input wire logic AUX_IRQ
);
    // ************
    // Bus and timer properties
    // ************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // One-cycle answer after setup
    property p_ready_answer; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
    property p_err_ready; PSLVERR |-> PREADY; endproperty
    // Read data moves only after a read setup
    property p_rdata_hold; $changed(PRDATA) |-> $past(PSEL && !PENABLE && !PWRITE); endproperty
    // Aux expiry pulses a tick apart
    property p_aux_pulse; AUX_TRIG |=> !AUX_TRIG [*3]; endproperty
    // Request rises on expiry or write
    property p_irq_rise;
        $rose(CHAN_IRQ[0]) |-> $past(CHAN_TRIG[0]) || $past(PSEL && PENABLE && PWRITE, 2);
    endproperty
    property p_aux_irq_rise;
        $rose(AUX_IRQ) |-> $past(AUX_TRIG) || $past(PSEL && PENABLE && PWRITE, 2);
    endproperty
    // Only a write can drop a request
    property p_irq_fall; $fell(CHAN_IRQ[0]) |-> $past(PSEL && PENABLE && PWRITE, 2); endproperty
    property p_aux_irq_fall; $fell(AUX_IRQ) |-> $past(PSEL && PENABLE && PWRITE, 2); endproperty
    // Quiet first edge after reset
    property p_reset_quiet;
        $rose(RSTN) |-> !PREADY && CHAN_TRIG == '0 && !AUX_TRIG && CHAN_IRQ == '0 && !AUX_IRQ;
    endproperty
    a_ready_answer: assert property (p_ready_answer) else $error("bad ready");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    a_aux_pulse: assert property (p_aux_pulse) else $error("aux trigger too long");
    a_irq_rise: assert property (p_irq_rise) else $error("chan irq no cause");
    a_aux_irq_rise: assert property (p_aux_irq_rise) else $error("aux irq no cause");
    a_irq_fall: assert property (p_irq_fall) else $error("chan irq fell alone");
    a_aux_irq_fall: assert property (p_aux_irq_fall) else $error("aux irq fell alone");
    a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
    c_chain_trig: cover property (CHAN_TRIG[1]);
    c_aux_trig: cover property (AUX_TRIG);
    c_bus_err: cover property (PSLVERR);
endmodule // timer_bank_chk
bind interval_timer_bank timer_bank_chk #(.NUM_CH(NUM_CH), .AUX_DIV(AUX_DIV)) chk (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CHAN_TRIG(CHAN_TRIG),
    .AUX_TRIG(AUX_TRIG), .CHAN_IRQ(CHAN_IRQ), .AUX_IRQ(AUX_IRQ));
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the interval timer bank.
// Assumes: NUM_CH 4, AUX_DIV 4.
// Notes: Bus-read counts allow for latency.
`timescale 1ns/100ps
`include "pit_consts.vh"
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic CLK_SYS = 1'b0; // System clock
    logic RSTN = 1'b0; // Reset, active low
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic DEBUG_HALT = 1'b0; // Core halted in debug
    wire [31:0] PRDATA;
    wire [3:0] CHAN_TRIG, CHAN_IRQ;
    wire PREADY, PSLVERR, AUX_TRIG, AUX_IRQ;
    int fail_count = 0; // Mismatches
    int checks = 0; // Comparisons
    logic [31:0] rd_v; // Last read word
    logic er_v; // Last error answer
    logic [31:0] a_v, b_v;
    int n_v, g_v;
    always #5 CLK_SYS = ~CLK_SYS;
    interval_timer_bank #(.NUM_CH(4), .AUX_DIV(4)) dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DEBUG_HALT(DEBUG_HALT),
        .CHAN_TRIG(CHAN_TRIG), .AUX_TRIG(AUX_TRIG), .CHAN_IRQ(CHAN_IRQ), .AUX_IRQ(AUX_IRQ));
    // ************
    // Bus and timing helpers
    // ************
    // One APB transfer, wait bounded
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do begin @(posedge CLK_SYS); n++; end while (PREADY !== 1'b1 && n < 50);
        rd_v = PRDATA;
        er_v = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 50) fail_count++;
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task automatic rreg(input logic [11:0] a); apb(1'b0, a, 32'h0000_0000); endtask
    function automatic logic [11:0] ca(input int n, input logic [1:0] r);
        ca = {`CH_REGION, 2'b00, n[1:0], r, 2'b00};
    endfunction
    // Index 4 stands for the aux timer
    function automatic logic trig(input int ch); trig = (ch > 3) ? AUX_TRIG : CHAN_TRIG[ch];
    endfunction
    // Edges to next trigger (n), then between two (g)
    task automatic gap(input int ch, output int n, output int g);
        n = 0;
        g = 0;
        do begin @(posedge CLK_SYS); n++; end while (trig(ch) !== 1'b1 && n < 400);
        do begin @(posedge CLK_SYS); g++; end while (trig(ch) !== 1'b1 && g < 400);
    endtask
    // ************
    // Scenarios
    // ************
    task automatic t_reset;
        rreg(`OFS_GCTRL); `CHK("gctrl", 32'h0000_0000, rd_v)
        rreg(ca(1, `CH_CTRL)); `CHK("ctrl1", 32'h0000_0000, rd_v)
        rreg(`OFS_AUX_CTRL); `CHK("auxctrl", 32'h0000_0000, rd_v)
        `CHK("irq", 4'h0, CHAN_IRQ)
        $display("test reset done");
    endtask
    task automatic t_period;
        wreg(ca(0, `CH_LOAD), 32'h0000_0002);
        wreg(ca(0, `CH_CTRL), 32'h0000_0003);
        gap(0, n_v, g_v); `CHK("period", 3, g_v)
        wreg(ca(0, `CH_LOAD), 32'h0000_0006);
        gap(0, n_v, g_v); `CHK("no restart", 1'b1, n_v <= 5)
        `CHK("new period", 7, g_v)
        `CHK("irq", 4'h1, CHAN_IRQ)
        wreg(ca(0, `CH_CTRL), 32'h0000_0002);
        rreg(ca(0, `CH_FLAG)); `CHK("flag", 32'h0000_0001, rd_v)
        wreg(ca(0, `CH_FLAG), 32'h0000_0001);
        rreg(ca(0, `CH_FLAG)); `CHK("flag clr", 32'h0000_0000, rd_v)
        `CHK("irq clr", 1'b0, CHAN_IRQ[0])
        wreg(ca(0, `CH_LOAD), 32'h0000_0028);
        wreg(ca(0, `CH_CTRL), 32'h0000_0001);
        repeat (20) @(posedge CLK_SYS);
        wreg(ca(0, `CH_CTRL), 32'h0000_0000);
        rreg(ca(0, `CH_COUNT)); a_v = rd_v;
        rreg(ca(0, `CH_COUNT)); `CHK("stopped", a_v, rd_v)
        wreg(ca(0, `CH_CTRL), 32'h0000_0001);
        rreg(ca(0, `CH_COUNT)); `CHK("reload", 1'b1, rd_v >= 32'h0000_0024)
        wreg(ca(0, `CH_CTRL), 32'h0000_0000);
        $display("test period done");
    endtask
    task automatic t_chain;
        wreg(ca(0, `CH_LOAD), 32'h0000_0003);
        wreg(ca(1, `CH_LOAD), 32'h0000_0002);
        wreg(ca(1, `CH_CTRL), 32'h0000_0004);
        wreg(ca(1, `CH_CTRL), 32'h0000_0005);
        wreg(ca(0, `CH_CTRL), 32'h0000_0007);
        rreg(ca(0, `CH_CTRL)); `CHK("ch0 chain", 32'h0000_0003, rd_v)
        gap(1, n_v, g_v); `CHK("life period", 12, g_v)
        wreg(ca(0, `CH_CTRL), 32'h0000_0000);
        rreg(`OFS_LIFE_HI); a_v = rd_v;
        rreg(`OFS_LIFE_LO); b_v = rd_v;
        rreg(ca(1, `CH_COUNT)); `CHK("life hi", rd_v, a_v)
        rreg(ca(0, `CH_COUNT)); `CHK("life lo", rd_v, b_v)
        $display("test chain done");
    endtask
    task automatic t_aux;
        wreg(`OFS_AUX_LOAD, 32'h0000_0001);
        rreg(`OFS_AUX_SYNC); `CHK("sync early", 32'h0000_0000, rd_v)
        for (int i = 0; i < 20 && rd_v[0] !== 1'b1; i++) rreg(`OFS_AUX_SYNC);
        `CHK("sync", 32'h0000_0001, rd_v)
        wreg(`OFS_AUX_CTRL, 32'h0000_0003);
        gap(4, n_v, g_v); `CHK("aux period", 8, g_v)
        gap(4, n_v, g_v); `CHK("aux again", 8, g_v)
        `CHK("aux irq", 1'b1, AUX_IRQ)
        wreg(`OFS_AUX_CTRL, 32'h0000_0000);
        rreg(`OFS_AUX_COUNT); a_v = rd_v;
        repeat (12) @(posedge CLK_SYS);
        rreg(`OFS_AUX_COUNT); `CHK("aux stop", a_v, rd_v)
        rreg(`OFS_AUX_FLAG); `CHK("aux flag", 32'h0000_0001, rd_v)
        wreg(`OFS_AUX_FLAG, 32'h0000_0001);
        rreg(`OFS_AUX_FLAG); `CHK("aux clr", 32'h0000_0000, rd_v)
        $display("test aux done");
    endtask
    task automatic t_debug;
        wreg(ca(2, `CH_LOAD), 32'h0000_03E8);
        wreg(ca(2, `CH_CTRL), 32'h0000_0001);
        DEBUG_HALT <= 1'b1;
        repeat (5) @(posedge CLK_SYS);
        rreg(ca(2, `CH_COUNT)); a_v = rd_v;
        repeat (10) @(posedge CLK_SYS);
        rreg(ca(2, `CH_COUNT)); `CHK("frozen", a_v, rd_v)
        wreg(`OFS_GCTRL, 32'h0000_0001);
        rreg(ca(2, `CH_COUNT)); `CHK("runs", 1'b1, rd_v < a_v)
        DEBUG_HALT <= 1'b0;
        wreg(`OFS_GCTRL, 32'h0000_0000);
        $display("test debug done");
    endtask
    // Each channel flags alone, no spill
    task automatic t_chans;
        for (int n = 0; n < 4; n++) begin
            wreg(ca(n, `CH_CTRL), 32'h0000_0000);
            wreg(ca(n, `CH_FLAG), 32'h0000_0001);
        end
        for (int n = 0; n < 4; n++) begin
            wreg(ca(n, `CH_LOAD), 32'h0000_0004);
            wreg(ca(n, `CH_CTRL), 32'h0000_0003);
            gap(n, n_v, g_v); `CHK("chan period", 5, g_v)
            wreg(ca(n, `CH_CTRL), 32'h0000_0002);
            `CHK("one irq", 4'h1 << n, CHAN_IRQ)
            wreg(ca(n, `CH_FLAG), 32'h0000_0001);
        end
        rreg(ca(3, `CH_LOAD));
        rreg(12'h0FC); `CHK("unmapped", 1'b1, er_v)
        `CHK("unmapped rdata", `RST_WORD, rd_v)
        $display("test channels done");
    endtask
    // ************
    // Sequence, verdict and watchdog
    // ************
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        t_reset();
        t_period();
        t_chain();
        t_aux();
        t_debug();
        t_chans();
        tally_and_finish();
    end
    // Run needs a few hundred cycles
    initial begin
        #400000;
        fail_count++;
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
